//--- design/dca_defines.vh
`ifndef DCA_DEFINES_VH
`define DCA_DEFINES_VH
// Register indices: printed offsets are not multiples of four,
// so each is an index and the byte address is four times it
`define DCA_IDX_SNAPSHOT 8'h4d
`define DCA_IDX_SECTOR 8'h4e
`define DCA_IDX_AUX 8'h4f
`define DCA_IDX_BUFDATA_A 8'h68
`define DCA_IDX_BUFDATA_B 8'h70
`define DCA_IDX_FMT_CTRL 8'h71
`define DCA_IDX_UNLOCK 8'h73
`define DCA_IDX_PINCFG 8'h7f
// Aux control field positions
`define DCA_AUX_ADV_MS 0
`define DCA_AUX_PASS_DIAG_PIN 1
`define DCA_AUX_SLAVE 2
`define DCA_AUX_XTBUSY 3
`define DCA_AUX_PUDIS 4
`define DCA_AUX_LPD 5
`define DCA_AUX_APD 6
`define DCA_AUX_DSLEEP 7
// Formatter reset bit in formatter control register
`define DCA_FMT_RST_BIT 5
// Pin function field in pin configuration register
`define DCA_PINCFG_LO 3
`define DCA_PINCFG_HI 4
`define DCA_PINCFG_OFF 2'b00
// Reset values
`define DCA_RST_BYTE 8'h00
`define DCA_RST_CNT 9'h000
`endif

//--- design/dca_sync2.v
`timescale 1ns/1ps
// Two-stage synchroniser for pins entering the pclk domain
module dca_sync2 #(
	parameter WIDTH = 1
) (
	// Clock and reset
	input wire pclk,
	input wire presetn,
	// Data
	input wire [WIDTH-1:0] d,
	output wire [WIDTH-1:0] q
);
	reg [WIDTH-1:0] meta_ff;
	reg [WIDTH-1:0] sync_ff;

	// First stage is read only by the second stage
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_ff <= {WIDTH{1'b0}};
			sync_ff <= {WIDTH{1'b0}};
		end else begin
			meta_ff <= d;
			sync_ff <= meta_ff;
		end
	end

	assign q = sync_ff;
endmodule // dca_sync2

//--- design/dca_carry_inhibit.v
`timescale 1ns/1ps
`include "dca_defines.vh"
// Counts sequencer count-field underflows and lets the carry pass only
// after sector size plus one of them have been suppressed
module dca_carry_inhibit #(
	parameter SW = 8
) (
	// Clock and reset
	input wire pclk,
	input wire presetn,
	// Control
	input wire inhibit_en,
	input wire [SW-1:0] sector_size,
	input wire underflow,
	input wire field_start,
	// Result
	output wire carry_out,
	output wire block_done
);
	reg [SW:0] cnt_ff;
	reg [SW:0] nxt_cnt;
	wire [SW:0] limit;

	assign limit = {1'b0, sector_size};

	// Underflow counter, restarts at each data field
	always @* begin
		nxt_cnt = cnt_ff;
		if (field_start || !inhibit_en)
			nxt_cnt = {(SW+1){1'b0}};
		else if (underflow && cnt_ff <= limit)
			nxt_cnt = cnt_ff + {{SW{1'b0}}, 1'b1};
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			cnt_ff <= {(SW+1){1'b0}};
		else
			cnt_ff <= nxt_cnt;
	end

	// Value zero inhibits one underflow, as the legacy formatter did
	assign carry_out = underflow & (!inhibit_en | (cnt_ff > limit));
	// Each suppressed underflow ends one 256-byte block
	assign block_done = underflow & inhibit_en & (cnt_ff <= limit);
endmodule // dca_carry_inhibit

//--- design/dca_aux_regs.v
`timescale 1ns/1ps
`include "dca_defines.vh"
// Operation
// - A buffer-data register read latches the buffer bus into the snapshot.
// - The snapshot clears on hardware reset and on the formatter reset bit.
// - With carry inhibit, sector size sets the 256-byte blocks per field.
// - Sector size plus one underflows are suppressed before carry passes.
// - Sector size zero gives the legacy carry-inhibit behaviour.
// - Advanced multisector set lets the sequencer run multisector itself.
// - The pass-diagnostics bit drives its pin and reads back the live pin.
// - Slave-present drives and reads its pin only while pin function is on.
// - In XT mode with clear-busy on, the completion byte read clears busy.
// - The pull-up disable bit turns off pull-ups on five host pins.
// - Local power-down ends on command write, host or hardware reset.
// - A command write locks local power-down; an unlock write frees it.
// - Host power-down ends only on host reset pin, reset or program reset.
// - Deep sleep ends only on host reset pin or hardware reset.
module dca_aux_regs (
	// Clock and reset
	input wire pclk,
	input wire presetn,
	// APB slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [9:0] paddr,
	input wire [31:0] pwdata,
	output wire [31:0] prdata,
	output wire pready,
	output wire pslverr,
	// Buffer memory data bus
	input wire [7:0] buf_data,
	// Formatter and register-file context
	input wire fmt_reset,
	input wire [1:0] pin_func,
	input wire xt_mode,
	// Host events, pulses from host logic on pclk
	input wire host_cmd_write,
	input wire host_prog_reset,
	input wire host_status_read,
	// Host reset pin, asynchronous
	input wire host_reset_pin,
	// Carry inhibit interface to sequencer
	input wire carry_inhibit_en,
	input wire count_underflow,
	input wire data_field_start,
	output wire count_carry,
	output wire block_done,
	// Sequencer mode and busy clear
	output reg adv_multisector,
	output reg clear_xt_busy,
	// Diagnostic pin, open drain
	input wire pass_diag_pin_in,
	output wire pass_diag_pin_out,
	output wire pass_diag_pin_oe,
	// Drive-active/slave pin, open drain
	input wire drive_active_slave_pin_in,
	output wire drive_active_slave_pin_out,
	output wire drive_active_slave_pin_oe,
	// Pull-up and power control
	output reg pullup_disable,
	output reg local_power_down,
	output reg host_power_down,
	output reg deep_sleep
);
	//----------------------------------------------------------------
	// Bus decode
	//----------------------------------------------------------------
	reg [7:0] snap_ff;
	reg [7:0] sector_ff;
	reg [7:0] aux_ff;
	reg lock_ff;
	reg [31:0] rdata;
	reg hit;
	wire [7:0] idx;
	wire acc;
	wire wr;
	wire rd;
	wire diag_sync;
	wire slave_sync;
	wire hreset_sync;
	wire slave_pin_on;

	assign idx = paddr[9:2];
	assign acc = psel & penable;
	assign wr = acc & pwrite;
	assign rd = acc & ~pwrite;
	// Zero wait states keep the access fixed at two cycles
	assign pready = 1'b1;
	assign pslverr = acc & ~hit;
	assign slave_pin_on = pin_func != `DCA_PINCFG_OFF;

	//----------------------------------------------------------------
	// Pin synchronisers
	//----------------------------------------------------------------
	dca_sync2 #(
		.WIDTH(3)
	) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.d({pass_diag_pin_in, drive_active_slave_pin_in, host_reset_pin}),
		.q({diag_sync, slave_sync, hreset_sync})
	);

	//----------------------------------------------------------------
	// Carry inhibit counter
	//----------------------------------------------------------------
	dca_carry_inhibit #(
		.SW(8)
	) u_carry (
		.pclk(pclk),
		.presetn(presetn),
		.inhibit_en(carry_inhibit_en),
		.sector_size(sector_ff),
		.underflow(count_underflow),
		.field_start(data_field_start),
		.carry_out(count_carry),
		.block_done(block_done)
	);

	//----------------------------------------------------------------
	// Read mux
	//----------------------------------------------------------------
	// Diag bit reads the live pin; slave bit reads it only while pin function is on, else the stored value
	always @* begin
		rdata = 32'h0000_0000;
		hit = 1'b1;
		case (idx)
		`DCA_IDX_SNAPSHOT: rdata[7:0] = snap_ff;
		`DCA_IDX_SECTOR: rdata[7:0] = sector_ff;
		`DCA_IDX_AUX: begin
			rdata[7:0] = aux_ff;
			rdata[`DCA_AUX_PASS_DIAG_PIN] = diag_sync;
			rdata[`DCA_AUX_SLAVE] = slave_pin_on ? slave_sync
				: aux_ff[`DCA_AUX_SLAVE];
		end
		`DCA_IDX_BUFDATA_A: rdata[7:0] = buf_data;
		`DCA_IDX_BUFDATA_B: rdata[7:0] = buf_data;
		`DCA_IDX_UNLOCK: rdata = 32'h0000_0000;
		default: hit = 1'b0;
		endcase
	end
	assign prdata = rdata;

	//----------------------------------------------------------------
	// Snapshot register
	//----------------------------------------------------------------
	// Formatter reset holds it clear even during a buffer read
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			snap_ff <= `DCA_RST_BYTE;
		end else if (fmt_reset) begin
			snap_ff <= `DCA_RST_BYTE;
		end else if (rd && (idx == `DCA_IDX_BUFDATA_A ||
			idx == `DCA_IDX_BUFDATA_B)) begin
			snap_ff <= buf_data;
		end
	end

	//----------------------------------------------------------------
	// Sector size and aux control
	//----------------------------------------------------------------
	// Power-down wake events: host reset pin and programmed reset
	// wake all three levels except deep sleep ignores programmed reset
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sector_ff <= `DCA_RST_BYTE;
			aux_ff <= `DCA_RST_BYTE;
			lock_ff <= 1'b0;
		end else begin
			if (wr && idx == `DCA_IDX_SECTOR)
				sector_ff <= pwdata[7:0];
			if (wr && idx == `DCA_IDX_AUX) begin
				aux_ff[4:0] <= pwdata[4:0];
				aux_ff[`DCA_AUX_APD] <= pwdata[`DCA_AUX_APD];
				aux_ff[`DCA_AUX_DSLEEP] <= pwdata[`DCA_AUX_DSLEEP];
				if (!lock_ff && !host_cmd_write)
					aux_ff[`DCA_AUX_LPD] <= pwdata[`DCA_AUX_LPD];
			end
			// Lock set wins over a same-cycle unlock
			if (host_cmd_write)
				lock_ff <= 1'b1;
			else if (wr && idx == `DCA_IDX_UNLOCK)
				lock_ff <= 1'b0;
			// Wake events override any write in the same cycle
			if (host_cmd_write || hreset_sync || host_prog_reset)
				aux_ff[`DCA_AUX_LPD] <= 1'b0;
			if (hreset_sync || host_prog_reset)
				aux_ff[`DCA_AUX_APD] <= 1'b0;
			if (hreset_sync)
				aux_ff[`DCA_AUX_DSLEEP] <= 1'b0;
		end
	end

	//----------------------------------------------------------------
	// Outputs
	//----------------------------------------------------------------
	// Mode bits go out as registered levels
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			adv_multisector <= 1'b0;
			pullup_disable <= 1'b0;
			local_power_down <= 1'b0;
			host_power_down <= 1'b0;
			deep_sleep <= 1'b0;
			clear_xt_busy <= 1'b0;
		end else begin
			adv_multisector <= aux_ff[`DCA_AUX_ADV_MS];
			pullup_disable <= aux_ff[`DCA_AUX_PUDIS];
			local_power_down <= aux_ff[`DCA_AUX_LPD];
			host_power_down <= aux_ff[`DCA_AUX_APD];
			deep_sleep <= aux_ff[`DCA_AUX_DSLEEP];
			clear_xt_busy <= xt_mode & aux_ff[`DCA_AUX_XTBUSY] &
				host_status_read;
		end
	end

	// Open drain: a zero bit pulls the active-low pin down, the slave pin only while pin function is on
	assign pass_diag_pin_out = 1'b0;
	assign pass_diag_pin_oe = ~aux_ff[`DCA_AUX_PASS_DIAG_PIN];
	assign drive_active_slave_pin_out = 1'b0;
	assign drive_active_slave_pin_oe = slave_pin_on &
		~aux_ff[`DCA_AUX_SLAVE];
endmodule // dca_aux_regs

//--- testbench/dca_chk.sv
`timescale 1ns/1ps
// Watches the auxiliary register block at its ports
module dca_chk (
	// Clock and reset
	input wire pclk,
	input wire presetn,
	// Bus and host events
	input wire psel,
	input wire xt_mode,
	input wire [1:0] pin_func,
	input wire host_cmd_write,
	input wire host_prog_reset,
	input wire host_status_read,
	input wire host_reset_pin,
	input wire carry_inhibit_en,
	input wire count_underflow,
	// Outputs watched
	input wire block_done,
	input wire clear_xt_busy,
	input wire pass_diag_pin_out,
	input wire drive_active_slave_pin_oe,
	input wire local_power_down,
	input wire host_power_down,
	input wire deep_sleep
);
	// ------
	// Properties
	// ------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	busy_clear_a: assert property (clear_xt_busy |->
		$past(host_status_read && xt_mode)) else $error("busy clear");
	diag_drain_a: assert property (!pass_diag_pin_out)
		else $error("diag pin driven high");
	slave_off_a: assert property (pin_func == 2'h0 |->
		!drive_active_slave_pin_oe) else $error("slave pin on");
	carry_hold_a: assert property (block_done |->
		count_underflow && carry_inhibit_en) else $error("block done");
	local_wake_a: assert property (host_cmd_write && local_power_down
		|-> ##[1:3] !local_power_down) else $error("local wake");
	host_wake_a: assert property (host_prog_reset && host_power_down
		|-> ##[1:3] !host_power_down) else $error("host wake");
	host_stay_a: assert property (host_power_down && host_cmd_write &&
		!psel && !$past(psel) |=> host_power_down) else $error("host pd");
	sleep_stay_a: assert property (deep_sleep && host_prog_reset &&
		!psel && !$past(psel) && !host_reset_pin |=> deep_sleep)
		else $error("deep sleep");
endmodule // dca_chk
bind dca_aux_regs dca_chk u_chk (.*);

//--- testbench/dca_pin_mdl.sv
`timescale 1ns/1ps
// Board side of the two open-drain pins
module dca_pin_mdl (
	// Clock and pull control
	input wire pclk,
	input wire pullup_disable,
	// Pin drivers and external pull-down
	input wire pass_diag_pin_out,
	input wire pass_diag_pin_oe,
	input wire drive_active_slave_pin_out,
	input wire drive_active_slave_pin_oe,
	input wire diag_low,
	input wire slave_low,
	// Resolved levels
	output wire pass_diag_pin_in,
	output wire drive_active_slave_pin_in
);
	reg tog_ff = 1'b0;
	// Floating line wanders so a stale value never reads back
	always @(posedge pclk) tog_ff <= !tog_ff;
	// Wired-AND with pull-up unless pull-ups are off
	assign pass_diag_pin_in = (pass_diag_pin_oe & !pass_diag_pin_out) |
		diag_low ? 1'b0 : pullup_disable ? tog_ff : 1'b1;
	assign drive_active_slave_pin_in = (drive_active_slave_pin_oe &
		!drive_active_slave_pin_out) | slave_low ? 1'b0 :
		pullup_disable ? tog_ff : 1'b1;
endmodule // dca_pin_mdl

//--- testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	// ------
	// Signals
	// ------
	localparam A_SN = 10'h134, A_SC = 10'h138, A_AX = 10'h13c;
	localparam A_BA = 10'h1a0, A_BB = 10'h1c0, A_UL = 10'h1cc;
	reg pclk, presetn, psel, penable, pwrite, fmt_reset, xt_mode;
	reg [9:0] paddr;
	reg [31:0] pwdata, rd;
	reg [7:0] buf_data;
	reg [1:0] pin_func;
	reg host_cmd_write, host_prog_reset, host_status_read, host_reset_pin;
	reg carry_inhibit_en, count_underflow, data_field_start;
	reg diag_low, slave_low, er;
	wire [31:0] prdata;
	wire pready, pslverr, count_carry, block_done, adv_multisector;
	wire clear_xt_busy, pass_diag_pin_in, pass_diag_pin_out;
	wire pass_diag_pin_oe, drive_active_slave_pin_in, pullup_disable;
	wire drive_active_slave_pin_out, drive_active_slave_pin_oe;
	wire local_power_down, host_power_down, deep_sleep;
	int num_errors = 0;
	int cmp_count = 0;
	int cyc = 0;
	dca_aux_regs dut (.*);
	dca_pin_mdl pm (.*);
	// ------
	// Tasks
	// ------
	task apb(input w, input [9:0] a, input [31:0] d);
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task chk(input [31:0] g, input [31:0] e);
		cmp_count++;
		if (g !== e) begin
			num_errors++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task rc(input [9:0] a, input [31:0] e);
		apb(0, a, 0);
		chk(rd, e);
	endtask
	// Lets registered outputs and pin synchronisers settle
	task hold;
		repeat (4) @(posedge pclk);
		@(negedge pclk);
	endtask
	task uf(input [1:0] e);
		@(posedge pclk) count_underflow <= 1;
		@(negedge pclk) chk({count_carry, block_done}, e);
		@(posedge pclk) count_underflow <= 0;
	endtask
	task fs;
		@(posedge pclk) data_field_start <= 1;
		@(posedge pclk) data_field_start <= 0;
	endtask
	task close_out;
		if (num_errors == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// ------
	// Scenarios
	// ------
	task t_snap;
		rc(A_SC, 0);
		rc(A_AX, 0);
		chk(adv_multisector, 0);
		apb(0, 10'h3fc, 0);
		chk(er, 1);
		buf_data <= 8'h5a;
		rc(A_BA, 32'h5a);
		rc(A_SN, 32'h5a);
		buf_data <= 8'hc3;
		rc(A_BB, 32'hc3);
		rc(A_SN, 32'hc3);
		@(posedge pclk) fmt_reset <= 1;
		@(posedge pclk) fmt_reset <= 0;
		rc(A_SN, 0);
	endtask
	task t_pins;
		apb(1, A_AX, 32'h2);
		hold;
		rc(A_AX, 32'h2);
		diag_low <= 1;
		hold;
		rc(A_AX, 0);
		diag_low <= 0;
		pin_func <= 2'h1;
		apb(1, A_AX, 32'h6);
		hold;
		rc(A_AX, 32'h6);
		slave_low <= 1;
		hold;
		rc(A_AX, 32'h2);
		slave_low <= 0;
		pin_func <= 2'h0;
	endtask
	task t_pwr;
		apb(1, A_AX, 32'h31);
		hold;
		chk(adv_multisector, 1);
		chk(pullup_disable, 1);
		chk(local_power_down, 1);
		@(posedge pclk) host_cmd_write <= 1;
		@(posedge pclk) host_cmd_write <= 0;
		hold;
		chk(local_power_down, 0);
		apb(1, A_AX, 32'h20);
		hold;
		chk(local_power_down, 0);
		apb(1, A_UL, 0);
		apb(1, A_AX, 32'h20);
		hold;
		chk(local_power_down, 1);
		apb(1, A_AX, 32'hc0);
		@(posedge pclk) host_cmd_write <= 1;
		@(posedge pclk) host_cmd_write <= 0;
		hold;
		chk({host_power_down, deep_sleep}, 2'h3);
		@(posedge pclk) host_prog_reset <= 1;
		@(posedge pclk) host_prog_reset <= 0;
		hold;
		chk({host_power_down, deep_sleep}, 2'h1);
		@(posedge pclk) host_reset_pin <= 1;
		repeat (4) @(posedge pclk);
		host_reset_pin <= 0;
		hold;
		chk(deep_sleep, 0);
	endtask
	task t_busy;
		apb(1, A_AX, 32'h8);
		xt_mode <= 1;
		@(posedge pclk) host_status_read <= 1;
		@(posedge pclk) host_status_read <= 0;
		@(negedge pclk) chk(clear_xt_busy, 1);
		@(posedge pclk) xt_mode <= 0;
		@(posedge pclk) host_status_read <= 1;
		@(posedge pclk) host_status_read <= 0;
		@(negedge pclk) chk(clear_xt_busy, 0);
	endtask
	// Two blocks per field with size one, legacy single block with zero
	task t_car;
		apb(1, A_SC, 32'h1);
		carry_inhibit_en <= 1;
		fs;
		uf(2'h1);
		uf(2'h1);
		uf(2'h2);
		apb(1, A_SC, 0);
		fs;
		uf(2'h1);
		uf(2'h2);
	endtask
	// ------
	// Run
	// ------
	initial begin
		pclk = 0;
		forever #12.5 pclk = ~pclk;
	end
	// Hang guard
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			num_errors++;
			close_out;
		end
	end
	initial begin
		{psel, penable, pwrite, paddr, pwdata, buf_data, fmt_reset} = 0;
		{pin_func, xt_mode, host_cmd_write, host_prog_reset} = 0;
		{host_status_read, host_reset_pin, carry_inhibit_en} = 0;
		{count_underflow, data_field_start, diag_low, slave_low} = 0;
		presetn = 0;
		repeat (20) @(posedge pclk);
		presetn <= 1;
		t_snap;
		t_pins;
		t_pwr;
		t_busy;
		t_car;
		close_out;
	end
endmodule // tb_top
